// *** src/psi_pkg.sv ***
// Package with the constants, types and helpers of the preset step indexer.
// How it works
// - Falling start edge begins an index cycle.
// - Emit preset count of pulses, up to 999999.
// - Digits are BCD, switch one weighs eight.
// - Move active rises as the cycle starts.
// - Move active falls after the last pulse.
// - Pulsing starts at the adjustable base rate.
// - Rate ramps from base toward maximum rate.
// - Maximum below base means base rate throughout.
// - Deceleration mirrors acceleration, ending at base rate.
// - Slope spans twenty to one, higher is slower.
// - Three acceleration time ranges chosen by two jumpers.
// - Ramp time set by range and slope jointly.
// - Four maximum frequency ranges: 2, 4, 20, 100 kHz.
// - Both rates zero: no pulses, cycle never ends.
// - Undriven start input reads high, never starts.
package psi_pkg;

	// System clock rate in hertz.
	localparam longint unsigned CLK_HZ = 20000000;

	// Width of the phase accumulator that shapes the step frequency.
	localparam int ACC_W = 24;

	// Full scale step frequencies of the four ranges, in hertz.
	localparam longint unsigned FREQ_2K_HZ = 2000;
	localparam longint unsigned FREQ_4K_HZ = 4000;
	localparam longint unsigned FREQ_20K_HZ = 20000;
	localparam longint unsigned FREQ_100K_HZ = 100000;

	// Accumulator increments that give each full scale frequency.
	localparam logic [ACC_W-1:0] INC_2K = ACC_W'(FREQ_2K_HZ * (64'd1 << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] INC_4K = ACC_W'(FREQ_4K_HZ * (64'd1 << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] INC_20K = ACC_W'(FREQ_20K_HZ * (64'd1 << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] INC_100K = ACC_W'(FREQ_100K_HZ * (64'd1 << ACC_W) / CLK_HZ);

	// Shortest zero to full speed time of each acceleration range, in microseconds.
	localparam longint unsigned ACC_FAST_MIN_US = 5000;
	localparam longint unsigned ACC_MID_MIN_US = 50000;
	localparam longint unsigned ACC_SLOW_MIN_US = 500000;

	// The same times as clock cycle counts.
	localparam int ACC_FAST_CYC = int'(ACC_FAST_MIN_US * CLK_HZ / 1000000);
	localparam int ACC_MID_CYC = int'(ACC_MID_MIN_US * CLK_HZ / 1000000);
	localparam int ACC_SLOW_CYC = int'(ACC_SLOW_MIN_US * CLK_HZ / 1000000);

	// A full ramp is cut into this many equal speed increments.
	localparam int RAMP_TICKS = 1024;
	localparam logic [15:0] RAMP_STEP = 16'h0040;

	// Slope setting limits; the span of the two is twenty to one.
	localparam logic [4:0] SLOPE_MIN = 5'h01;
	localparam logic [4:0] SLOPE_MAX = 5'h14;

	// Register byte offsets on the APB bus.
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_PRESET = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_SPEED = 12'h00C;

	// Reset values of the writable registers.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [23:0] PRESET_RST = 24'h00_0000;

	// Acceleration range codes of the two jumpers.
	localparam logic [1:0] ACC_RANGE_FAST = 2'h0;
	localparam logic [1:0] ACC_RANGE_MID = 2'h1;

	// Frequency range one-hot select bits.
	localparam int FSEL_2K = 0;
	localparam int FSEL_4K = 1;
	localparam int FSEL_20K = 2;
	localparam int FSEL_100K = 3;

	// Control register layout, most significant field first.
	typedef struct packed {
		logic [3:0] pad_hi;
		logic [3:0] freq_sel;
		logic [1:0] acc_range;
		logic pad_lo;
		logic [4:0] slope;
		logic [7:0] max_speed;
		logic [7:0] base_speed;
	} psi_ctrl_s;

	// Motion phases of an index cycle.
	typedef enum logic [1:0] {
		PSI_IDLE = 2'b00,
		PSI_ACCEL = 2'b01,
		PSI_CRUISE = 2'b10,
		PSI_DECEL = 2'b11
	} psi_state_e;

	// Converts six BCD digits, least significant digit in the low nibble, to binary.
	// A digit code above nine is read as nine so the count never passes 999999.
	function automatic logic [19:0] psi_bcd_to_bin(input logic [23:0] bcd);
		logic [19:0] acc;
		logic [3:0] dig;
		acc = 20'h0_0000;
		dig = 4'h0;
		for (int i = 5; i >= 0; i--) begin
			dig = bcd[i*4 +: 4];
			if (dig > 4'h9) begin
				dig = 4'h9;
			end
			acc = 20'((acc * 20'h0_000A) + {16'h0000, dig});
		end
		return acc;
	endfunction

endpackage

// *** src/psi_sync.sv ***
// Three stage synchroniser with agreement filter for an asynchronous pin.
`timescale 1ns/1ns
module psi_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic pin_i,
	output logic level_o
);
	logic meta; // First stage, read only by the second.
	logic s2; // Second stage.
	logic s3; // Third stage.

	// Shift the pin through three flops; the reset value stands for an idle pin.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end else begin
			meta <= pin_i;
			s2 <= meta;
			s3 <= s2;
		end
	end

	// The clean level follows only once the last two stages agree, which rejects one-cycle glitches.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			level_o <= RST_VAL;
		end else if (s2 == s3) begin
			level_o <= s3;
		end
	end
endmodule // psi_sync

// *** src/psi_step_gen.sv ***
// Phase accumulator step pulse generator with square wave output.
`timescale 1ns/1ns
module psi_step_gen
	import psi_pkg::*;
#(
	parameter int W = ACC_W
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic clear_i,
	input wire logic [W-1:0] inc_i,
	output logic step_o,
	output logic rise_o
);
	logic [W-1:0] phase; // Running phase.
	logic [W-1:0] next_phase; // Phase after this cycle's addition.

	// The addition wraps on purpose; the wrap is one full step period.
	assign next_phase = W'(phase + inc_i);

	// Accumulate; a clear restarts at zero so each cycle begins with a whole low half period.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase <= '0;
		end else if (clear_i) begin
			phase <= '0;
		end else begin
			phase <= next_phase;
		end
	end

	// The top phase bit is high for half of each period at any rate.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			step_o <= 1'b0;
			rise_o <= 1'b0;
		end else if (clear_i) begin
			step_o <= 1'b0;
			rise_o <= 1'b0;
		end else begin
			step_o <= next_phase[W-1];
			rise_o <= next_phase[W-1] & ~phase[W-1];
		end
	end
endmodule // psi_step_gen

// *** src/psi_indexer.sv ***
// Preset step indexer top level: APB registers, ramp control and step counting.
`timescale 1ns/1ns
module psi_indexer
	import psi_pkg::*;
#(
	parameter int ACC_FAST_CYCLES = ACC_FAST_CYC,
	parameter int ACC_MID_CYCLES = ACC_MID_CYC,
	parameter int ACC_SLOW_CYCLES = ACC_SLOW_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic start_n_i,
	output logic step_o,
	output logic move_active_o
);
	// Ramp tick lengths for a slope setting of one.
	localparam logic [23:0] TICK_FAST = 24'(ACC_FAST_CYCLES / RAMP_TICKS);
	localparam logic [23:0] TICK_MID = 24'(ACC_MID_CYCLES / RAMP_TICKS);
	localparam logic [23:0] TICK_SLOW = 24'(ACC_SLOW_CYCLES / RAMP_TICKS);

	psi_ctrl_s ctrl; // Speed, slope and range settings.
	logic [23:0] preset_bcd; // Six preset digits.
	psi_state_e state; // Motion phase.
	logic [19:0] remaining; // Pulses still to issue.
	logic [19:0] ramp_steps; // Pulses issued while accelerating.
	logic [15:0] speed; // Present speed, fraction of full scale.
	logic [23:0] ramp_cnt; // Cycles since the last ramp tick.
	logic start_lvl; // Filtered start pin.
	logic start_prev; // Start level one cycle earlier.
	logic start_fall; // One-cycle falling edge pulse.
	logic step_rise; // One-cycle pulse at each step rising edge.
	logic [ACC_W-1:0] full_inc; // Increment at full scale speed.
	logic [ACC_W-1:0] step_inc; // Increment at the present speed.
	logic [15:0] base_q; // Base speed scaled to sixteen bits.
	logic [15:0] max_q; // Maximum speed scaled to sixteen bits.
	logic [4:0] slope_eff; // Slope setting held within its span.
	logic [23:0] tick_base; // Tick length of the selected range.
	logic [23:0] tick_len; // Tick length after slope scaling.
	logic ramp_tick; // One-cycle pulse at each ramp tick.
	logic range_ok; // A frequency range is selected.
	logic cycle_done; // The last pulse has been issued and has ended.
	logic near_end; // Remaining pulses fit in the mirrored ramp.
	logic apb_wr; // Write access phase.
	logic apb_setup; // Setup phase of any transfer.

	// Synchronise the start pin; an idle reset level of one means an open input never starts.
	psi_sync #(
		.RST_VAL(1'b1)
	) u_start_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pin_i(start_n_i),
		.level_o(start_lvl)
	);

	// Remember the previous start level for the edge detector.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			start_prev <= 1'b1;
		end else begin
			start_prev <= start_lvl;
		end
	end

	// High to low transition of the filtered start input.
	// Both flops reset high, so the release of reset never looks like a press.
	assign start_fall = start_prev & ~start_lvl;

	// Scale eight-bit settings to sixteen bits so that setting 255 is exactly full scale.
	assign base_q = {ctrl.base_speed, ctrl.base_speed};
	assign max_q = {ctrl.max_speed, ctrl.max_speed};

	// Any selected range lets the block run; with none it stays idle.
	assign range_ok = |ctrl.freq_sel;

	// Pick the full scale increment; the fastest selected range wins if several are set.
	always_comb begin
		if (ctrl.freq_sel[FSEL_100K]) begin
			full_inc = INC_100K;
		end else if (ctrl.freq_sel[FSEL_20K]) begin
			full_inc = INC_20K;
		end else if (ctrl.freq_sel[FSEL_4K]) begin
			full_inc = INC_4K;
		end else if (ctrl.freq_sel[FSEL_2K]) begin
			full_inc = INC_2K;
		end else begin
			full_inc = '0;
		end
	end

	// Present speed times full scale; zero speed gives a zero increment and thus no pulses.
	assign step_inc = ACC_W'(({24'h00_0000, speed} * {16'h0000, full_inc}) >> 16);

	// The generator is held cleared outside a cycle so the output rests low.
	psi_step_gen #(
		.W(ACC_W)
	) u_step_gen (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.clear_i(state == PSI_IDLE),
		.inc_i(step_inc),
		.step_o(step_o),
		.rise_o(step_rise)
	);

	// Hold the slope within its twenty to one span.
	always_comb begin
		if (ctrl.slope < SLOPE_MIN) begin
			slope_eff = SLOPE_MIN;
		end else if (ctrl.slope > SLOPE_MAX) begin
			slope_eff = SLOPE_MAX;
		end else begin
			slope_eff = ctrl.slope;
		end
	end

	// Range picks the base tick; a larger slope lengthens it and so lowers the acceleration.
	always_comb begin
		case (ctrl.acc_range)
			ACC_RANGE_FAST: begin
				tick_base = TICK_FAST;
			end
			ACC_RANGE_MID: begin
				tick_base = TICK_MID;
			end
			default: begin
				tick_base = TICK_SLOW;
			end
		endcase
		tick_len = 24'(tick_base * {19'h0_0000, slope_eff});
	end

	// Count out ramp ticks while the speed is changing.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ramp_cnt <= 24'h00_0000;
		end else if (state == PSI_IDLE || state == PSI_CRUISE || ramp_tick) begin
			ramp_cnt <= 24'h00_0000;
		end else begin
			ramp_cnt <= 24'(ramp_cnt + 24'h00_0001);
		end
	end

	// A ramp tick closes one speed increment; the count rests outside the ramps.
	assign ramp_tick = (ramp_cnt + 24'h00_0001) >= tick_len;

	// End of cycle: nothing left and the last pulse has gone low again.
	assign cycle_done = (remaining == 20'h0_0000) && !step_o;

	// Begin the slow-down once the pulses left are no more than those the speed-up used.
	assign near_end = remaining <= ramp_steps;

	// Motion phase sequencing.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= PSI_IDLE;
		end else begin
			case (state)
				PSI_IDLE: begin
					// A start with no range chosen is dropped, not kept for later.
					if (start_fall && range_ok) begin
						state <= PSI_ACCEL;
					end
				end
				PSI_ACCEL: begin
					// A maximum at or below base skips the ramp and cruises at base.
					if (cycle_done) begin
						state <= PSI_IDLE;
					end else if (speed >= max_q || max_q <= base_q) begin
						state <= PSI_CRUISE;
					end else if (near_end) begin
						state <= PSI_DECEL;
					end
				end
				PSI_CRUISE: begin
					if (cycle_done) begin
						state <= PSI_IDLE;
					end else if (near_end && ramp_steps != 20'h0_0000) begin
						state <= PSI_DECEL;
					end
				end
				PSI_DECEL: begin
					// The slow-down runs on until the last pulse has ended.
					if (cycle_done) begin
						state <= PSI_IDLE;
					end
				end
				default: begin
					state <= PSI_IDLE;
				end
			endcase
		end
	end

	// Speed profile: start at base, climb by ticks, and fall back by the same ticks.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			speed <= 16'h0000;
		end else if (state == PSI_IDLE) begin
			speed <= base_q;
		end else if (state == PSI_ACCEL && ramp_tick && max_q > base_q) begin
			if ({1'b0, speed} + {1'b0, RAMP_STEP} >= {1'b0, max_q}) begin
				speed <= max_q;
			end else begin
				speed <= 16'(speed + RAMP_STEP);
			end
		end else if (state == PSI_DECEL && ramp_tick) begin
			if (speed <= 16'(base_q + RAMP_STEP) || speed < RAMP_STEP) begin
				speed <= base_q;
			end else begin
				speed <= 16'(speed - RAMP_STEP);
			end
		end
	end

	// Pulse bookkeeping: load the preset on start, count each rising edge down.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			remaining <= 20'h0_0000;
		end else if (state == PSI_IDLE) begin
			if (start_fall && range_ok) begin
				remaining <= psi_bcd_to_bin(preset_bcd);
			end
		end else if (step_rise && remaining != 20'h0_0000) begin
			remaining <= 20'(remaining - 20'h0_0001);
		end
	end

	// Pulses issued during the speed-up size the mirrored slow-down.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ramp_steps <= 20'h0_0000;
		end else if (state == PSI_IDLE) begin
			ramp_steps <= 20'h0_0000;
		end else if (state == PSI_ACCEL && step_rise && max_q > base_q) begin
			ramp_steps <= 20'(ramp_steps + 20'h0_0001);
		end
	end

	// Move active rises with the start and stays up while a cycle runs; edges meanwhile are ignored.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			move_active_o <= 1'b0;
		end else if (state == PSI_IDLE) begin
			move_active_o <= start_fall && range_ok;
		end else begin
			move_active_o <= !cycle_done;
		end
	end

	// APB decode; the slave never inserts wait states.
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign pready_o = 1'b1;

	// Writable registers take effect only in the access phase.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl <= CTRL_RST;
			preset_bcd <= PRESET_RST;
		end else if (apb_wr) begin
			if (paddr_i == REG_CTRL) begin
				ctrl <= {4'h0, pwdata_i[27:22], 1'b0, pwdata_i[20:0]};
			end else if (paddr_i == REG_PRESET) begin
				preset_bcd <= pwdata_i[23:0];
			end
		end
	end

	// Read data and error are captured in the setup phase so they stand through the access.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (apb_setup) begin
			pslverr_o <= 1'b0;
			case (paddr_i)
				REG_CTRL: begin
					prdata_o <= ctrl;
				end
				REG_PRESET: begin
					prdata_o <= {8'h00, preset_bcd};
				end
				REG_STATUS: begin
					prdata_o <= {8'h00, remaining, 1'b0, state, move_active_o};
				end
				REG_SPEED: begin
					prdata_o <= {16'h0000, speed};
				end
				default: begin
					// Unmapped offsets answer with an error and read as zero.
					prdata_o <= 32'h0000_0000;
					pslverr_o <= 1'b1;
				end
			endcase
		end
	end
endmodule // psi_indexer

// *** sim/psi_indexer_properties.sv ***
// Concurrent checks on the ports of the preset step indexer.
`timescale 1ns/1ns
module psi_indexer_properties (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic start_n_i,
	input wire logic step_o,
	input wire logic move_active_o
);
	// Every check shares the one clock and is quiet during reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// The bus slave never inserts wait states.
	property p_ready; pready_o; endproperty
	a_ready: assert property (p_ready) else $error("pready seen low");

	// A refused access returns zero data.
	property p_err_data; pslverr_o |-> prdata_o == 32'h0000_0000; endproperty
	a_err_data: assert property (p_err_data) else $error("error read not zero");

	// A cycle only begins after the start pin has been low for a while.
	property p_start; $rose(move_active_o) |-> !$past(start_n_i, 2) && !$past(start_n_i, 3);
	endproperty
	a_start: assert property (p_start) else $error("cycle began without start");

	// A pin held high never begins a cycle.
	property p_idle; (start_n_i && !move_active_o) [*8] |=> !move_active_o; endproperty
	a_idle: assert property (p_idle) else $error("cycle began with pin high");

	// The step line moves only inside a cycle.
	property p_step_in; $changed(step_o) |-> move_active_o; endproperty
	a_step_in: assert property (p_step_in) else $error("step outside a cycle");

	// The cycle closes only after the last pulse has fallen.
	property p_end; $fell(move_active_o) |-> !step_o && !$past(step_o); endproperty
	a_end: assert property (p_end) else $error("cycle closed with step high");

	// Pulsing starts from a cleared phase, so the line stays low a while.
	property p_first; $rose(move_active_o) |-> !step_o [*8]; endproperty
	a_first: assert property (p_first) else $error("step high at cycle start");

	// A square wave at 100 kHz at most keeps each high level long.
	property p_high; $rose(step_o) |-> step_o [*8]; endproperty
	a_high: assert property (p_high) else $error("step pulse too short");

	c_start: cover property ($rose(move_active_o));
	c_end: cover property ($fell(move_active_o));
	c_err: cover property (pslverr_o);
endmodule // psi_indexer_properties

bind psi_indexer psi_indexer_properties psi_indexer_properties_inst (
	.clk_i(clk_i), .nrst_i(nrst_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .start_n_i(start_n_i), .step_o(step_o),
	.move_active_o(move_active_o));

// *** sim/psi_drive_model.sv ***
// Model of the drive's step input and of the start push switch.
`timescale 1ns/1ns
module psi_drive_model (
	input wire logic clk_i,
	input wire logic press_i,
	input wire logic step_i,
	input wire logic move_active_i,
	output logic start_n_o
);
	int n_steps = 0; // Rising step edges since time zero.
	int period = 0; // Clocks between the last two rising edges.
	int min_period = 0; // Shortest period of the present cycle.
	int since = 0; // Clocks since the last rising edge.
	int hold = 0; // Clocks the switch stays closed.
	logic step_q = 1'b0;
	logic act_q = 1'b0;
	logic first = 1'b0; // No rising step edge seen yet in the present cycle.

	// An open switch leaves the pin to the pull-up, so it reads high.
	assign start_n_o = (hold == 0);

	// Switch timing and step edge counting; the first rise of a cycle closes
	// a period that spans the idle gap, so it is kept out of the minimum.
	always @(posedge clk_i) begin
		hold <= press_i ? 8 : (hold > 0 ? hold - 1 : 0);
		step_q <= step_i;
		act_q <= move_active_i;
		since <= since + 1;
		if (move_active_i && !act_q) begin
			min_period <= 1000000;
			first <= 1'b1;
		end
		if (step_i && !step_q) begin
			n_steps <= n_steps + 1;
			period <= since;
			since <= 1;
			first <= 1'b0;
			if (!first && since < min_period) begin
				min_period <= since;
			end
		end
	end
endmodule // psi_drive_model

// *** sim/psi_indexer_test.sv ***
// Self-checking bench for the preset step indexer.
`timescale 1ns/1ns
module psi_indexer_test
	import psi_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic press = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic start_n;
	logic step;
	logic move_active;
	logic [31:0] rd; // Data of the last read.
	logic err; // Error flag of the last access.
	int n_mismatch = 0;
	int n_compared = 0;
	int hi;
	int dur[4]; // Cycle lengths of the ramp runs.
	int exp_p;
	int freqs[4] = '{int'(FREQ_2K_HZ), int'(FREQ_4K_HZ), int'(FREQ_20K_HZ), int'(FREQ_100K_HZ)};

	// Short ramp counts keep the run brief.
	psi_indexer #(.ACC_FAST_CYCLES(2048), .ACC_MID_CYCLES(4096), .ACC_SLOW_CYCLES(8192))
	psi_indexer_inst (.clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .start_n_i(start_n), .step_o(step),
		.move_active_o(move_active));
	psi_drive_model psi_drive_model_inst (.clk_i(clk), .press_i(press), .step_i(step),
		.move_active_i(move_active), .start_n_o(start_n));

	// 20 MHz clock.
	always #25 clk = ~clk;

	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			stop_test();
		end
	endtask

	task automatic set_ctrl(input logic [7:0] base, input logic [7:0] top,
		input logic [4:0] slope, input logic [1:0] rng, input logic [3:0] fsel);
		psi_ctrl_s c;
		c = psi_ctrl_s'(32'h0000_0000);
		c.base_speed = base;
		c.max_speed = top;
		c.slope = slope;
		c.acc_range = rng;
		c.freq_sel = fsel;
		apb(REG_CTRL, 1'b1, c);
	endtask

	// Closes the switch for one clock; the model holds it for eight.
	task automatic push();
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
	endtask

	// Runs one index cycle and checks the pulse count; hi returns its length.
	task automatic index_run(input logic [23:0] bcd, input int exp_n, input bit retrig,
		output int hi);
		int n0;
		apb(REG_PRESET, 1'b1, {8'h00, bcd});
		n0 = psi_drive_model_inst.n_steps;
		push();
		hi = 0;
		for (int n = 0; n < 20 && move_active !== 1'b1; n++) @(posedge clk);
		check(move_active, 1'b1);
		while (move_active === 1'b1) begin
			@(posedge clk);
			hi++;
			press <= retrig && hi == 300 && move_active === 1'b1;
			if (hi > 60000) begin
				n_mismatch++;
				stop_test();
			end
		end
		check(psi_drive_model_inst.n_steps - n0, exp_n);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		apb(REG_CTRL, 1'b0, 32'h0000_0000);
		check(rd, CTRL_RST);
		apb(REG_PRESET, 1'b0, 32'h0000_0000);
		check(rd, {8'h00, PRESET_RST});
		apb(REG_STATUS, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(12'h010, 1'b0, 32'h0000_0000);
		check(err, 1'b1);
		// Unused control bits read back as zero.
		apb(REG_CTRL, 1'b1, 32'hF8F4_FFFF);
		apb(REG_CTRL, 1'b0, 32'h0000_0000);
		check(rd, 32'h08D4_FFFF);
		// With no frequency range chosen the start is refused.
		set_ctrl(8'hFF, 8'hFF, 5'h01, ACC_RANGE_FAST, 4'h0);
		push();
		repeat (20) @(posedge clk);
		check(move_active, 1'b0);
		// Each range at full speed sets the step period.
		foreach (freqs[i]) begin
			set_ctrl(8'hFF, 8'hFF, 5'h01, ACC_RANGE_FAST, 4'(1 << i));
			index_run(24'h00_0002, 2, 1'b0, hi);
			exp_p = int'(CLK_HZ) / freqs[i];
			check(psi_drive_model_inst.period inside {[exp_p*98/100:exp_p*103/100]}, 1'b1);
		end
		index_run(24'h00_0000, 0, 1'b0, hi);
		check(hi, 1);
		// A second press in mid-cycle must not stretch or restart it.
		index_run(24'h00_0012, 12, 1'b1, hi);
		repeat (30) @(posedge clk);
		check(move_active, 1'b0);
		// Ramps from a low base in every acceleration range.
		for (int r = 0; r < 3; r++) begin
			set_ctrl(8'h20, 8'hFF, 5'h01, 2'(r), 4'h8);
			index_run(24'h00_0030, 30, 1'b0, dur[r]);
			check(psi_drive_model_inst.min_period < 1440, 1'b1);
			check(psi_drive_model_inst.period >= psi_drive_model_inst.min_period * 3 / 2
				&& psi_drive_model_inst.period <= 1700, 1'b1);
		end
		set_ctrl(8'h20, 8'hFF, 5'h0A, ACC_RANGE_FAST, 4'h8);
		index_run(24'h00_0030, 30, 1'b0, dur[3]);
		check(dur[1] > dur[0] && dur[2] > dur[1], 1'b1);
		check(dur[3] > dur[0], 1'b1);
		// Maximum below base: every period stays at the base rate.
		set_ctrl(8'h80, 8'h10, 5'h01, ACC_RANGE_FAST, 4'h8);
		index_run(24'h00_0020, 20, 1'b0, hi);
		check(psi_drive_model_inst.min_period inside {[395:405]}, 1'b1);
		// Between cycles the speed rests at the base setting scaled to full scale.
		apb(REG_SPEED, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_8080);
		// Both rates zero: the cycle hangs until a reset ends it.
		set_ctrl(8'h00, 8'h00, 5'h01, ACC_RANGE_FAST, 4'h8);
		apb(REG_PRESET, 1'b1, 32'h0000_0005);
		push();
		repeat (2000) @(posedge clk);
		check(move_active, 1'b1);
		// Still cruising with all five pulses owed.
		apb(REG_STATUS, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0055);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		check(move_active, 1'b0);
		apb(REG_CTRL, 1'b0, 32'h0000_0000);
		check(rd, CTRL_RST);
		stop_test();
	end
endmodule // psi_indexer_test
